// ===== cict_core_timing.sv
/*
   Instruction length and cycle-timing sequencer of the 8-bit core, with
   routing of external-data and code-read accesses to on-chip storage.
   Assumes the fetch logic presents an opcode with opValid and holds the
   operand values (A, R0, R1, data pointer, PC) stable during issue.
*/
`timescale 1ns/1ps

module cict_core_timing (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Instruction issue
   input wire logic opValid,
   input wire logic [7:0] opCode,
   input wire logic branchTaken,
   output logic opReady,
   // Core operand values
   input wire logic [7:0] accValue,
   input wire logic [7:0] r0Value,
   input wire logic [7:0] r1Value,
   input wire logic [15:0] dptrValue,
   input wire logic [15:0] pcValue,
   input wire logic progStoreWriteEnable,
   // Timing status
   output logic busy,
   output logic instDone,
   output logic opKnown,
   output logic [1:0] instLength,
   output logic [3:0] instCycles,
   output logic [3:0] cycleIndex,
   // On-chip data and program store access
   output logic [15:0] xdataAddr,
   output logic [7:0] xdataWrData,
   output logic onchipExternalDataRamRead,
   output logic onchipExternalDataRamWrite,
   output logic progStoreWrite,
   output logic [15:0] codeAddr,
   output logic codeRead
);

   function automatic cict_pkg::cict_decode_type mk(
      input logic known,
      input cict_pkg::cict_class_type cls,
      input logic [1:0] len,
      input logic [3:0] cyc
   );
      cict_pkg::cict_decode_type d;
      d.known = known;
      d.cls = cls;
      d.len = len;
      d.cyc = cyc;
      return d;
   endfunction : mk

   // Branch rows give the not-taken time; taken adds one at issue
   function automatic cict_pkg::cict_decode_type decode(
      input logic [7:0] op
   );
      cict_pkg::cict_decode_type d;
      d = mk(1'b0, cict_pkg::CLS_PLAIN, cict_pkg::LEN_1, cict_pkg::CYC_1);
      if (op[3]) begin
         // Bank register column
         case (op[7:4])
            4'h7, 4'h8, 4'hA: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
            4'hB: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            4'hD: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
            default: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_1);
            end
         endcase
      end else if (op[3:1] == 3'h3) begin
         // Indirect RAM column through R0 or R1
         case (op[7:4])
            4'h7, 4'h8, 4'hA: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
            4'hB: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            4'hD: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_2);
            end
            default: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_2);
            end
         endcase
      end else if (op[3:0] == 4'h5) begin
         // Direct byte column
         case (op[7:4])
            4'h7, 4'h8: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            4'hA: begin
               // Spare opcode acts as a no-op
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_1);
            end
            4'hB, 4'hD: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            default: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
         endcase
      end else if (op[3:0] == 4'h4) begin
         // Accumulator and immediate column
         case (op[7:4])
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_1);
            end
            4'h8: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_8);
            end
            4'hA: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_4);
            end
            4'hB: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            default: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
         endcase
      end else begin
         case (op)
            8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'hA3: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_1);
            end
            8'h42, 8'h52, 8'h62, 8'hC0, 8'hD0: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
            8'h43, 8'h53, 8'h63, 8'h90: begin
               d = mk(1'b1, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            8'h83, 8'h93: begin
               d = mk(1'b1, cict_pkg::CLS_CODEREAD,
                      cict_pkg::LEN_1, cict_pkg::CYC_3);
            end
            8'hE0, 8'hE2, 8'hE3: begin
               d = mk(1'b1, cict_pkg::CLS_XREAD,
                      cict_pkg::LEN_1, cict_pkg::CYC_3);
            end
            8'hF0, 8'hF2, 8'hF3: begin
               d = mk(1'b1, cict_pkg::CLS_XWRITE,
                      cict_pkg::LEN_1, cict_pkg::CYC_3);
            end
            8'h10, 8'h20, 8'h30: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_3, cict_pkg::CYC_3);
            end
            8'h40, 8'h50, 8'h60, 8'h70: begin
               d = mk(1'b1, cict_pkg::CLS_BRANCH,
                      cict_pkg::LEN_2, cict_pkg::CYC_2);
            end
            default: begin
               // Rows outside this block time as one byte, one cycle
               d = mk(1'b0, cict_pkg::CLS_PLAIN,
                      cict_pkg::LEN_1, cict_pkg::CYC_1);
            end
         endcase
      end
      return d;
   endfunction : decode

   cict_pkg::cict_state_type state;
   cict_pkg::cict_class_type cls;
   cict_pkg::cict_decode_type dec;
   logic [3:0] remaining;
   logic [3:0] next_cycles;
   logic [7:0] riValue;
   logic [15:0] next_xdataAddr;
   logic lastCycle;
   logic accept;

   assign dec = decode(opCode);
   assign lastCycle = (state == cict_pkg::ST_EXEC) &&
                      (remaining == cict_pkg::CYC_1);
   // A new opcode may issue in the final cycle of the previous one
   assign opReady = (state == cict_pkg::ST_IDLE) || lastCycle;
   assign accept = opValid && opReady;
   assign busy = (state == cict_pkg::ST_EXEC);
   assign instDone = lastCycle;
   assign riValue = opCode[cict_pkg::RI_SEL_BIT] ? r1Value : r0Value;

   always_comb begin
      next_cycles = dec.cyc;
      if (dec.cls == cict_pkg::CLS_BRANCH && branchTaken) begin
         next_cycles = dec.cyc + cict_pkg::BRANCH_TAKEN_EXTRA;
      end
      if (next_cycles > cict_pkg::CYC_MAX) begin
         next_cycles = cict_pkg::CYC_MAX;
      end
   end

   // 8-bit form takes R0/R1 with a zero page; 16-bit form the pointer
   always_comb begin
      if (opCode[1]) begin
         next_xdataAddr = {cict_pkg::ADDR_HI_ZERO, riValue};
      end else begin
         next_xdataAddr = dptrValue;
      end
   end

   // Sequencer: one count per system clock, no machine-cycle prescale
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= cict_pkg::ST_IDLE;
         remaining <= cict_pkg::CYC_IDX_RESET;
      end else begin
         case (state)
            cict_pkg::ST_IDLE: begin
               if (accept) begin
                  state <= cict_pkg::ST_EXEC;
                  remaining <= next_cycles;
               end
            end
            cict_pkg::ST_EXEC: begin
               if (accept) begin
                  remaining <= next_cycles;
               end else if (lastCycle) begin
                  state <= cict_pkg::ST_IDLE;
                  remaining <= cict_pkg::CYC_IDX_RESET;
               end else begin
                  remaining <= remaining - cict_pkg::CYC_1;
               end
            end
            default: begin
               state <= cict_pkg::ST_IDLE;
               remaining <= cict_pkg::CYC_IDX_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cycleIndex <= cict_pkg::CYC_IDX_RESET;
      end else if (accept) begin
         cycleIndex <= cict_pkg::CYC_IDX_RESET;
      end else if (busy) begin
         cycleIndex <= cycleIndex + cict_pkg::CYC_1;
      end
   end

   // Decoded figures of the instruction in flight
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         instLength <= cict_pkg::LEN_1;
         instCycles <= cict_pkg::CYC_1;
         opKnown <= 1'b0;
         cls <= cict_pkg::CLS_PLAIN;
      end else if (accept) begin
         instLength <= dec.len;
         instCycles <= next_cycles;
         opKnown <= dec.known;
         cls <= dec.cls;
      end
   end

   // Addresses and data are latched at issue so operand changes in
   // later cycles cannot disturb the access
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xdataAddr <= cict_pkg::ADDR_RESET;
         xdataWrData <= cict_pkg::DATA_RESET;
         codeAddr <= cict_pkg::ADDR_RESET;
      end else if (accept) begin
         xdataAddr <= next_xdataAddr;
         xdataWrData <= accValue;
         if (opCode[4]) begin
            codeAddr <= dptrValue + {cict_pkg::ADDR_HI_ZERO, accValue};
         end else begin
            codeAddr <= pcValue + {14'h0000, dec.len} +
                        {cict_pkg::ADDR_HI_ZERO, accValue};
         end
      end
   end

   // Every external-data access lands on chip; there is no pin path
   always_comb begin
      onchipExternalDataRamRead = 1'b0;
      onchipExternalDataRamWrite = 1'b0;
      progStoreWrite = 1'b0;
      codeRead = 1'b0;
      if (lastCycle) begin
         case (cls)
            cict_pkg::CLS_XREAD: begin
               onchipExternalDataRamRead = 1'b1;
            end
            cict_pkg::CLS_XWRITE: begin
               progStoreWrite = progStoreWriteEnable;
               onchipExternalDataRamWrite = !progStoreWriteEnable;
            end
            cict_pkg::CLS_CODEREAD: begin
               codeRead = 1'b1;
            end
            default: begin
               codeRead = 1'b0;
            end
         endcase
      end
   end

endmodule : cict_core_timing

// ===== cict_core_timing_checker.sv
/*
   Checker for the cycle-timing block: execution counts, strobes and
   routed addresses. Assumes it is bound to the block's own ports.
*/
`timescale 1ns/1ps

module cict_core_timing_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Issue
   input wire logic opValid,
   input wire logic [7:0] opCode,
   input wire logic branchTaken,
   input wire logic opReady,
   // Operands
   input wire logic [7:0] accValue,
   input wire logic [7:0] r0Value,
   input wire logic [15:0] dptrValue,
   input wire logic [15:0] pcValue,
   input wire logic progStoreWriteEnable,
   // Status and access
   input wire logic busy,
   input wire logic instDone,
   input wire logic [1:0] instLength,
   input wire logic [3:0] instCycles,
   input wire logic [3:0] cycleIndex,
   input wire logic [15:0] xdataAddr,
   input wire logic onchipExternalDataRamRead,
   input wire logic onchipExternalDataRamWrite,
   input wire logic progStoreWrite,
   input wire logic [15:0] codeAddr,
   input wire logic codeRead
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire logic issue = opValid && opReady;
   sequence doneAfter4; !instDone [*3] ##1 instDone; endsequence
   sequence doneAfter8; !instDone [*7] ##1 instDone; endsequence

   done_index_a:
   assert property (instDone |-> cycleIndex == instCycles - 4'h1)
      else $error("done outside last cycle");
   index_step_a:
   assert property (busy && !instDone |=>
      busy && cycleIndex == $past(cycleIndex) + 4'h1)
      else $error("cycle index did not step");
   cycle_cap_a:
   assert property (busy |-> instCycles <= 4'h8 && instCycles != 4'h0)
      else $error("cycle count out of range");
   mul_time_a:
   assert property (issue && opCode == 8'hA4 |=>
      (instCycles == 4'h4) ##0 doneAfter4)
      else $error("multiply timing wrong");
   div_time_a:
   assert property (issue && opCode == 8'h84 |=>
      (instCycles == 4'h8) ##0 doneAfter8)
      else $error("divide timing wrong");
   branch_time_a:
   assert property (issue && opCode == 8'h40 |=>
      instCycles == ($past(branchTaken) ? 4'h3 : 4'h2))
      else $error("branch timing wrong");
   dptr_load_a:
   assert property (issue && opCode == 8'h90 |=>
      instLength == 2'h3 && instCycles == 4'h3)
      else $error("pointer load timing wrong");
   ri_addr_a:
   assert property (issue && opCode == 8'hF2 |=>
      xdataAddr == {8'h00, $past(r0Value)})
      else $error("short address wrong");
   movx_dptr_a:
   assert property (issue && opCode == 8'hF0 |=>
      (xdataAddr == $past(dptrValue)) ##2
      (instDone && (onchipExternalDataRamWrite || progStoreWrite)))
      else $error("long address write wrong");
   store_route_a:
   assert property (onchipExternalDataRamWrite || progStoreWrite |->
      instDone && progStoreWrite == progStoreWriteEnable &&
      !(onchipExternalDataRamWrite && progStoreWrite))
      else $error("write routed wrongly");
   movc_pc_a:
   assert property (issue && opCode == 8'h83 |=>
      codeAddr == $past(pcValue) + 16'h0001 + {8'h00, $past(accValue)})
      else $error("code address wrong");
   onchip_strobe_a:
   assert property (onchipExternalDataRamRead || codeRead |->
      instDone && !(onchipExternalDataRamRead && codeRead))
      else $error("read strobe misplaced");
endmodule : cict_core_timing_checker

bind cict_core_timing cict_core_timing_checker cict_core_timing_checker_inst (
   .clk_sys, .resetn, .opValid, .opCode, .branchTaken, .opReady, .accValue,
   .r0Value, .dptrValue, .pcValue, .progStoreWriteEnable, .busy, .instDone,
   .instLength, .instCycles, .cycleIndex, .xdataAddr,
   .onchipExternalDataRamRead, .onchipExternalDataRamWrite,
   .progStoreWrite, .codeAddr, .codeRead);

// ===== cict_pkg.sv
/*
   Package for the core instruction cycle-timing block: instruction
   lengths, cycle counts, access classes and sequencer states.
   Assumes one system clock; nothing here is tied to a bus or pin.
*/
package cict_pkg;

   // Operand and address widths
   localparam int OP_W = 8;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;

   // Instruction lengths in program bytes
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   // Execution times in system clock cycles
   localparam logic [3:0] CYC_1 = 4'h1;
   localparam logic [3:0] CYC_2 = 4'h2;
   localparam logic [3:0] CYC_3 = 4'h3;
   localparam logic [3:0] CYC_4 = 4'h4;
   localparam logic [3:0] CYC_8 = 4'h8;
   localparam logic [3:0] CYC_MAX = 4'h8;
   localparam logic [3:0] BRANCH_TAKEN_EXTRA = 4'h1;
   localparam logic [3:0] CYC_IDX_RESET = 4'h0;

   // Reset values of the data-side outputs, and the zero high byte of short addresses
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] ADDR_HI_ZERO = 8'h00;

   // Opcode field positions
   localparam int RI_SEL_BIT = 0;

   // What an instruction does beyond internal registers
   typedef enum logic [4:0] {
      CLS_PLAIN    = 5'b00001,
      CLS_BRANCH   = 5'b00010,
      CLS_XREAD    = 5'b00100,
      CLS_XWRITE   = 5'b01000,
      CLS_CODEREAD = 5'b10000
   } cict_class_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } cict_state_type;

   typedef struct packed {
      logic known;
      cict_class_type cls;
      logic [1:0] len;
      logic [3:0] cyc;
   } cict_decode_type;

endpackage : cict_pkg

// ===== tb_top.sv
/*
   Self-checking bench for the cycle-timing block: opcode timing tables,
   branches, routed accesses, held requests and reset.
   Assumes the checker is bound separately.
*/
`timescale 1ns/1ps

module tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic opValid = 1'b0;
   logic [7:0] opCode = 8'h00;
   logic branchTaken = 1'b0;
   logic [7:0] accValue = 8'h3C;
   logic [7:0] r0Value = 8'h5A;
   logic [7:0] r1Value = 8'hA7;
   logic [15:0] dptrValue = 16'h12F0;
   logic [15:0] pcValue = 16'h0FFE;
   logic progStoreWriteEnable = 1'b0;
   logic opReady, busy, instDone, opKnown;
   logic [1:0] instLength;
   logic [3:0] instCycles, cycleIndex;
   logic [15:0] xdataAddr, codeAddr;
   logic [7:0] xdataWrData;
   logic onchipExternalDataRamRead, onchipExternalDataRamWrite;
   logic progStoreWrite, codeRead;
   logic [3:0] strobes;
   int failures = 0;
   int compares = 0;
   int ticks = 0;
   int seen;
   // Rows are opcode, length, cycles
   localparam logic [15:0] regRows [8] = '{16'h2811, 16'h3811, 16'h9811,
      16'h5811, 16'h4811, 16'h6811, 16'hE811, 16'hC811};
   localparam logic [15:0] indRows [8] = '{16'h2612, 16'h3612, 16'h9612,
      16'h5612, 16'h4612, 16'h6612, 16'hE612, 16'hC612};
   localparam logic [15:0] dirRows [6] = '{16'h2522, 16'h2422, 16'h5522,
      16'h5422, 16'h7422, 16'hE522};
   localparam logic [15:0] immDir [3] = '{16'h5333, 16'h4333, 16'h6333};
   localparam logic [15:0] incRows [9] = '{16'h0411, 16'h0811, 16'h0522,
      16'h0612, 16'h1411, 16'h1811, 16'h1522, 16'h1612, 16'hA311};
   localparam logic [15:0] accRows [8] = '{16'hE411, 16'hF411, 16'h2311,
      16'h3311, 16'h0311, 16'h1311, 16'hC411, 16'hD411};
   localparam logic [15:0] longRows [3] = '{16'h9033, 16'h8533, 16'h7533};
   localparam logic [15:0] codeRows [2] = '{16'h9313, 16'h8313};
   localparam logic [15:0] xRows [6] = '{16'hE013, 16'hE213, 16'hE313,
      16'hF013, 16'hF213, 16'hF313};
   localparam logic [15:0] stackRows [2] = '{16'hC022, 16'hD022};
   localparam logic [15:0] digitRows [2] = '{16'hD612, 16'hD712};
   localparam logic [15:0] moveRows [3] = '{16'h8622, 16'hA622, 16'h7622};
   localparam logic [15:0] longOps [2] = '{16'hA414, 16'h8418};
   localparam logic [15:0] nopRows [2] = '{16'h0011, 16'hA511};

   cict_core_timing cict_core_timing_inst (.clk_sys, .resetn, .opValid,
      .opCode, .branchTaken, .opReady, .accValue, .r0Value, .r1Value,
      .dptrValue, .pcValue, .progStoreWriteEnable, .busy, .instDone,
      .opKnown, .instLength, .instCycles, .cycleIndex, .xdataAddr,
      .xdataWrData, .onchipExternalDataRamRead,
      .onchipExternalDataRamWrite, .progStoreWrite, .codeAddr,
      .codeRead);

   always #20 clk_sys = ~clk_sys;

   // Far above the few hundred cycles the scenarios need
   always @(posedge clk_sys) begin
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         failures++;
         results();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic issue(input logic [7:0] op, input logic tk,
         input logic pswe);
      @(posedge clk_sys);
      opValid <= 1'b1;
      opCode <= op;
      branchTaken <= tk;
      progStoreWriteEnable <= pswe;
      @(posedge clk_sys);
      opValid <= 1'b0;
      seen = 0;
      do begin
         @(negedge clk_sys);
         seen++;
      end while (instDone !== 1'b1 && seen < 12);
      strobes = {onchipExternalDataRamRead, onchipExternalDataRamWrite,
         progStoreWrite, codeRead};
   endtask : issue

   task automatic timeRow(input logic [15:0] e);
      issue(e[15:8], 1'b0, 1'b0);
      chk("done cycle", 16'(e[3:0]), 16'(seen));
      chk("instCycles", 16'(e[3:0]), 16'(instCycles));
      chk("instLength", 16'(e[7:4]), 16'(instLength));
      chk("opKnown", 16'h0001, 16'(opKnown));
   endtask : timeRow

   task automatic timingTables;
      foreach (regRows[i]) timeRow(regRows[i]);
      foreach (indRows[i]) timeRow(indRows[i]);
      foreach (dirRows[i]) timeRow(dirRows[i]);
      foreach (immDir[i]) timeRow(immDir[i]);
      foreach (incRows[i]) timeRow(incRows[i]);
      foreach (accRows[i]) timeRow(accRows[i]);
      foreach (longRows[i]) timeRow(longRows[i]);
      foreach (codeRows[i]) timeRow(codeRows[i]);
      foreach (xRows[i]) timeRow(xRows[i]);
      foreach (stackRows[i]) timeRow(stackRows[i]);
      foreach (digitRows[i]) timeRow(digitRows[i]);
      foreach (moveRows[i]) timeRow(moveRows[i]);
      foreach (longOps[i]) timeRow(longOps[i]);
      foreach (nopRows[i]) timeRow(nopRows[i]);
   endtask : timingTables

   task automatic branchTiming;
      issue(8'h40, 1'b1, 1'b0);
      chk("taken cycles", 16'h0003, 16'(seen));
      issue(8'h40, 1'b0, 1'b0);
      chk("untaken cycles", 16'h0002, 16'(seen));
      chk("branch length", 16'h0002, 16'(instLength));
   endtask : branchTiming

   task automatic xdataAccess;
      issue(8'hE3, 1'b0, 1'b1);
      chk("r1 address", {8'h00, r1Value}, xdataAddr);
      chk("read strobes", 16'h0008, 16'(strobes));
      issue(8'hF0, 1'b0, 1'b0);
      chk("dptr address", dptrValue, xdataAddr);
      chk("write data", 16'(accValue), 16'(xdataWrData));
      chk("ram write", 16'h0004, 16'(strobes));
      issue(8'hF2, 1'b0, 1'b1);
      chk("r0 address", {8'h00, r0Value}, xdataAddr);
      chk("store write", 16'h0002, 16'(strobes));
      issue(8'h93, 1'b0, 1'b0);
      chk("dptr code", dptrValue + 16'(accValue), codeAddr);
      chk("code read", 16'h0001, 16'(strobes));
      issue(8'h83, 1'b0, 1'b0);
      chk("pc code", pcValue + 16'h0001 + 16'(accValue), codeAddr);
   endtask : xdataAccess

   task automatic backToBack;
      @(posedge clk_sys);
      opValid <= 1'b1;
      opCode <= 8'hA4;
      @(posedge clk_sys);
      opCode <= 8'hE4;
      // Offer stands while busy; it must be refused, not stored
      @(negedge clk_sys);
      chk("refused ready", 16'h0001, 16'({opReady, busy}));
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("held done", 16'h0001, 16'(instDone));
      chk("held cycles", 16'h0004, 16'(instCycles));
      @(posedge clk_sys);
      opValid <= 1'b0;
      @(negedge clk_sys);
      chk("next done", 16'h0001, 16'(instDone));
      chk("next cycles", 16'h0001, 16'(instCycles));
   endtask : backToBack

   task automatic checkReset;
      @(negedge clk_sys);
      chk("reset flags", 16'h0040, 16'({busy, opReady, instDone, opKnown,
         onchipExternalDataRamRead, onchipExternalDataRamWrite,
         progStoreWrite, codeRead}));
      chk("reset counts", 16'h0110, 16'({instLength, instCycles,
         cycleIndex}));
      chk("reset addresses", 16'h0000, xdataAddr | codeAddr);
   endtask : checkReset

   task automatic midReset;
      @(posedge clk_sys);
      opValid <= 1'b1;
      opCode <= 8'h84;
      @(posedge clk_sys);
      opValid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b0;
      checkReset();
      @(posedge clk_sys);
      resetn <= 1'b1;
      issue(8'h84, 1'b0, 1'b0);
      chk("divide after reset", 16'h0008, 16'(seen));
   endtask : midReset

   task automatic results;
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (8) @(posedge clk_sys);
      checkReset();
      @(posedge clk_sys);
      resetn <= 1'b1;
      timingTables();
      branchTiming();
      xdataAccess();
      backToBack();
      midReset();
      results();
   end
endmodule : tb_top
